// *** common/scb_pkg.sv ***
package scb_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SCK_PERIOD_NS = 320;
  localparam int SCK_HALF_CYC  = ((SCK_PERIOD_NS / 2) / CLK_PERIOD_NS < 1) ? 1 :
                                 (SCK_PERIOD_NS / 2) / CLK_PERIOD_NS;

  // ==========================================================================
  // Register file map
  localparam logic [6:0] RF_STATUS_ADDR = 7'h28;
  localparam logic [6:0] RF_WAIT_ADDR   = 7'h2a;

  // ==========================================================================
  // Field positions
  localparam int STAT_SF8_BIT  = 3;
  localparam int STAT_SF9_BIT  = 2;
  localparam int STAT_SSTT_BIT = 1;
  localparam int STAT_BSY_BIT  = 0;
  localparam int WAIT_ACK_BIT  = 3;
  localparam int WAIT_NWT_BIT  = 2;
  localparam int WAIT_WRQ_LSB  = 0;

  // ==========================================================================
  // Reset values and counts
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [3:0] WAIT_RESET   = 4'h0;
  localparam logic [3:0] CNT_INIT     = 4'h0;
  localparam logic [3:0] CNT_WRAP     = 4'h1;
  localparam logic [3:0] CNT_EIGHT    = 4'h8;
  localparam logic [3:0] CNT_NINE     = 4'h9;

  // ==========================================================================
  // Wait request codes
  localparam logic [1:0] WRQ_NONE = 2'h0;
  localparam logic [1:0] WRQ_DATA = 2'h1;
  localparam logic [1:0] WRQ_ACK  = 2'h2;
  localparam logic [1:0] WRQ_ADDR = 2'h3;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic count_eight_flag;
    logic count_nine_flag;
    logic start_seen_flag;
    logic bus_busy_flag;
  } scb_status_s;

  typedef struct packed {
    logic       acknowledge_bit;
    logic       wait_release_flag;
    logic [1:0] wait_request;
  } scb_wait_s;

  typedef struct packed {
    logic protocol_select;
    logic clock_source_select;
    logic transmit_select;
  } scb_mode_s;

endpackage

// *** rtl/scb_sync.sv ***
`timescale 1ns/100ps
module scb_sync
  import scb_pkg::*;
(
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic pin_in,
  output logic      lvl_out
);

  logic meta_q;

  // ==========================================================================
  // Two-stage synchroniser, idle high
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_q  <= 1'b1;
      lvl_out <= 1'b1;
    end else begin
      meta_q  <= pin_in;
      lvl_out <= meta_q;
    end
  end

endmodule // scb_sync

// *** rtl/scb_edge.sv ***
`timescale 1ns/100ps
module scb_edge
  import scb_pkg::*;
(
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic lvl,
  output logic      rise,
  output logic      fall
);

  logic prev_q;

  // ==========================================================================
  // Edge finder on a synchronised level
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= lvl;
    end
  end

  assign rise = lvl & ~prev_q;
  assign fall = ~lvl & prev_q;

endmodule // scb_edge

// *** rtl/scb_core.sv ***
// Operation
// - Counter starts at 0, steps by one per counted shift clock rise.
// - After 9 the next rise wraps the counter to 1.
// - Bus mode: counter clears on reset, stop, start condition, leaving bus mode.
// - Serial mode: counter clears on reset, stop, wait write, entering bus mode.
// - Read-only status register at 28H: eight, nine, start, busy flags.
// - Bus mode: busy sets on start condition, clears on stop condition.
// - Serial mode forces busy to 0 until bus mode returns.
// - Bus mode: start-seen sets on start, clears when counter becomes 9.
// - Nine flag sets at count 9, clears at count 0 or 1.
// - Eight flag sets at count 8, clears at count 0 or 1.
// - Wait register: ack, release, two request bits; cleared by reset and stop.
// - While waiting, counter and shift register see no shift clock.
// - Codes: none, fall at 8, fall at 9, first fall at 8 after start.
// - Internal serial clock stops high at count 8 or 9.
// - Bus slave wait drives the clock line low; none without a request.
// - Writing 1 to release leaves wait; the wait point waits again.
// - Bus master holds its generated clock low while waiting at a wait point.
// - Internal serial: wait write restarts count; no-wait runs clock continuously.
// - External serial clock: counting and shifting stop at the wait point.
// - Release flag reads back whether the interface is waiting.
// - Protocol select 0 is serial mode, 1 is two-wire bus mode.
// - Clock source select: slave or master, external or internal clock.
// - Writing 0 to release forces an immediate wait.
`timescale 1ns/100ps
module scb_core
  import scb_pkg::*;
#(
  parameter int HALF_CYC = SCK_HALF_CYC
) (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       stop_clk,
  input  wire scb_mode_s  mode,
  input  wire logic [6:0] rf_addr,
  input  wire logic       rf_wr,
  input  wire logic [3:0] rf_wdata,
  output logic [3:0]      rf_rdata,
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            shift_rise,
  output logic            shift_fall
);

  // ==========================================================================
  // Pin synchronisers and edge finders
  logic scl_s;
  logic sda_s;
  logic pin_rise;
  logic pin_fall;
  logic sda_rise;
  logic sda_fall;

  scb_sync u_sync_scl (
    .mclk    (mclk),
    .nrst    (nrst),
    .pin_in  (scl_in),
    .lvl_out (scl_s)
  );

  scb_sync u_sync_sda (
    .mclk    (mclk),
    .nrst    (nrst),
    .pin_in  (sda_in),
    .lvl_out (sda_s)
  );

  scb_edge u_edge_scl (
    .mclk (mclk),
    .nrst (nrst),
    .lvl  (scl_s),
    .rise (pin_rise),
    .fall (pin_fall)
  );

  scb_edge u_edge_sda (
    .mclk (mclk),
    .nrst (nrst),
    .lvl  (sda_s),
    .rise (sda_rise),
    .fall (sda_fall)
  );

  // ==========================================================================
  // State
  logic [3:0]  cnt_q, cnt_d;
  scb_status_s stat_q, stat_d;
  scb_wait_s   wait_q, wait_d;
  logic        prot_q, prot_d;
  logic        arm_q, arm_d;
  logic        gen_q, gen_d;
  logic [7:0]  div_q, div_d;
  logic        ackph_q, ackph_d;
  logic [3:0]  rdata_q, rdata_d;
  logic        scl_out_q, scl_out_d;
  logic        scl_oe_q, scl_oe_d;
  logic        sda_oe_q, sda_oe_d;
  logic        srise_q, srise_d;
  logic        sfall_q, sfall_d;

  // ==========================================================================
  // Decode of mode and events
  logic       bus;
  logic       int_gen;
  logic       sio_int;
  logic       waiting;
  logic       wr_wait;
  logic       start_det;
  logic       stop_det;
  logic       gen_tgl;
  logic       rise;
  logic       fall;
  logic       cnt_clr;
  logic [3:0] cnt_inc;
  logic [3:0] wp_cnt;
  logic       wp;

  always_comb begin
    bus       = mode.protocol_select;
    int_gen   = mode.clock_source_select;
    sio_int   = ~bus & int_gen;
    waiting   = ~wait_q.wait_release_flag;
    wr_wait   = rf_wr && (rf_addr == RF_WAIT_ADDR);
    start_det = scl_s & sda_fall;
    stop_det  = scl_s & sda_rise;
    gen_tgl   = int_gen && !waiting && (div_q == 8'(HALF_CYC - 1));
    // Shift clock gated while waiting
    rise      = ~waiting & (int_gen ? (gen_tgl & ~gen_q) : pin_rise);
    fall      = ~waiting & (int_gen ? (gen_tgl & gen_q) : pin_fall);
    cnt_inc   = (cnt_q == CNT_NINE) ? CNT_WRAP : 4'(cnt_q + 4'h1);
    cnt_clr   = stop_clk | (bus & start_det) | (prot_q != bus)
              | (~bus & wr_wait);
    wp_cnt    = (wait_q.wait_request == WRQ_DATA) ? CNT_EIGHT : CNT_NINE;
    // Wait point per request code
    if (wait_q.wait_request == WRQ_NONE) begin
      wp = 1'b0;
    end else if (wait_q.wait_request == WRQ_ADDR) begin
      wp = bus & fall & arm_q & (cnt_q == CNT_EIGHT);
    end else if (sio_int) begin
      wp = rise & (cnt_inc == wp_cnt);
    end else begin
      wp = fall & (cnt_q == wp_cnt);
    end
  end

  // ==========================================================================
  // Counter, status flags and wait register
  always_comb begin
    cnt_d  = cnt_q;
    stat_d = stat_q;
    wait_d = wait_q;
    prot_d = bus;
    arm_d  = arm_q;
    if (cnt_clr) begin
      cnt_d = CNT_INIT;
    end else if (rise) begin
      cnt_d = cnt_inc;
    end
    if (cnt_d == CNT_EIGHT) begin
      stat_d.count_eight_flag = 1'b1;
    end else if (cnt_d <= CNT_WRAP) begin
      stat_d.count_eight_flag = 1'b0;
    end
    if (cnt_d == CNT_NINE) begin
      stat_d.count_nine_flag = 1'b1;
    end else if (cnt_d <= CNT_WRAP) begin
      stat_d.count_nine_flag = 1'b0;
    end
    if (!bus) begin
      stat_d.bus_busy_flag   = 1'b0;
      stat_d.start_seen_flag = 1'b0;
    end else begin
      if (start_det) begin
        stat_d.bus_busy_flag = 1'b1;
      end else if (stop_det) begin
        stat_d.bus_busy_flag = 1'b0;
      end
      if (start_det) begin
        stat_d.start_seen_flag = 1'b1;
      end else if (cnt_d == CNT_NINE && cnt_q != CNT_NINE) begin
        stat_d.start_seen_flag = 1'b0;
      end
    end
    // Address wait arms on start, fires once
    if (bus & start_det) begin
      arm_d = 1'b1;
    end else if (wp && wait_q.wait_request == WRQ_ADDR) begin
      arm_d = 1'b0;
    end
    if (wr_wait) begin
      wait_d = scb_wait_s'(rf_wdata);
    end
    if (bus & mode.transmit_select & rise & (cnt_inc == CNT_NINE)) begin
      wait_d.acknowledge_bit = sda_s;
    end
    if (wp) begin
      wait_d.wait_release_flag = 1'b0;
    end
    if (stop_clk) begin
      wait_d = scb_wait_s'(WAIT_RESET);
      arm_d  = 1'b0;
    end
  end

  // ==========================================================================
  // Shift clock generator, pin drive and shift strobes
  always_comb begin
    div_d   = 8'h00;
    gen_d   = gen_q;
    ackph_d = ackph_q;
    if (!int_gen) begin
      gen_d = 1'b1;
    end else if (!waiting) begin
      div_d = gen_tgl ? 8'h00 : 8'(div_q + 8'h01);
      gen_d = gen_tgl ? ~gen_q : gen_q;
    end else begin
      div_d = div_q;
    end
    if (!bus || stop_clk) begin
      ackph_d = 1'b0;
    end else if (fall) begin
      ackph_d = (cnt_q == CNT_EIGHT);
    end
    if (bus && !int_gen) begin
      scl_oe_d  = waiting && (wait_q.wait_request != WRQ_NONE);
      scl_out_d = 1'b0;
    end else if (bus) begin
      scl_oe_d  = ~gen_d;
      scl_out_d = 1'b0;
    end else begin
      scl_oe_d  = int_gen;
      scl_out_d = gen_d;
    end
    sda_oe_d = bus & ~mode.transmit_select & ackph_d & ~wait_q.acknowledge_bit;
    srise_d  = rise & (~bus | (cnt_d != CNT_NINE & cnt_d != CNT_INIT));
    sfall_d  = fall & (~bus | (cnt_q != CNT_NINE & cnt_q != CNT_INIT));
    if (rf_addr == RF_STATUS_ADDR) begin
      rdata_d = stat_q;
    end else if (rf_addr == RF_WAIT_ADDR) begin
      rdata_d = wait_q;
    end else begin
      rdata_d = 4'h0;
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_q     <= CNT_INIT;
      stat_q    <= scb_status_s'(STATUS_RESET);
      wait_q    <= scb_wait_s'(WAIT_RESET);
      prot_q    <= 1'b0;
      arm_q     <= 1'b0;
      gen_q     <= 1'b1;
      div_q     <= 8'h00;
      ackph_q   <= 1'b0;
      rdata_q   <= 4'h0;
      scl_out_q <= 1'b1;
      scl_oe_q  <= 1'b0;
      sda_oe_q  <= 1'b0;
      srise_q   <= 1'b0;
      sfall_q   <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      stat_q    <= stat_d;
      wait_q    <= wait_d;
      prot_q    <= prot_d;
      arm_q     <= arm_d;
      gen_q     <= gen_d;
      div_q     <= div_d;
      ackph_q   <= ackph_d;
      rdata_q   <= rdata_d;
      scl_out_q <= scl_out_d;
      scl_oe_q  <= scl_oe_d;
      sda_oe_q  <= sda_oe_d;
      srise_q   <= srise_d;
      sfall_q   <= sfall_d;
    end
  end

  assign rf_rdata   = rdata_q;
  assign scl_out    = scl_out_q;
  assign scl_oe     = scl_oe_q;
  assign sda_out    = 1'b0;
  assign sda_oe     = sda_oe_q;
  assign shift_rise = srise_q;
  assign shift_fall = sfall_q;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  AST_CNT_RANGE: assert property (cnt_q <= CNT_NINE)
    else $error("Counter left 0..9");
  AST_CNT_WRAP: assert property (rise && !cnt_clr && cnt_q == CNT_NINE |=> cnt_q == CNT_WRAP)
    else $error("Counter did not wrap to 1");
  AST_CNT_START: assert property (bus && start_det |=> cnt_q == CNT_INIT)
    else $error("Start did not clear counter");
  AST_CNT_WRITE: assert property (!bus && wr_wait |=> cnt_q == CNT_INIT)
    else $error("Wait write did not clear counter in serial mode");
  AST_BSY_START: assert property (bus && $past(bus) && start_det |=> stat_q.bus_busy_flag)
    else $error("Busy not set on start");
  AST_BSY_SIO: assert property (!bus ##1 !bus |-> !stat_q.bus_busy_flag)
    else $error("Busy not held 0 in serial mode");
  AST_SSTT_NINE: assert property (bus && $rose(cnt_q == CNT_NINE) |-> !stat_q.start_seen_flag)
    else $error("Start-seen not cleared at count 9");
  AST_SF9: assert property (cnt_q == CNT_NINE |-> stat_q.count_nine_flag)
    else $error("Nine flag not set at count 9");
  AST_SF8: assert property (cnt_q <= CNT_WRAP |-> !stat_q.count_eight_flag && !stat_q.count_nine_flag)
    else $error("Count flags not cleared at count 0 or 1");
  AST_STOP_CLR: assert property (stop_clk |=> wait_q == scb_wait_s'(WAIT_RESET))
    else $error("Stop did not clear wait register");
  AST_FREEZE: assert property (waiting && !cnt_clr |=> $stable(cnt_q) && !shift_rise)
    else $error("Counter moved while waiting");
  AST_SIO_HIGH: assert property (sio_int && wp |=> gen_q && waiting ##1 gen_q)
    else $error("Internal serial clock not stopped high");
  AST_SLAVE_LOW: assert property (bus && !int_gen && wp |=> ##1 scl_oe && !scl_out)
    else $error("Slave wait did not hold clock low");
  AST_RELEASE: assert property (wr_wait && rf_wdata[WAIT_NWT_BIT] && !wp && !stop_clk |=> !waiting)
    else $error("Release write did not leave wait");
  AST_MASTER_LOW: assert property (bus && int_gen && wp |=> !gen_q [*3])
    else $error("Master clock not held low while waiting");
  AST_FORCE: assert property (wr_wait && !rf_wdata[WAIT_NWT_BIT] |=> waiting)
    else $error("Forced wait not taken");

  COV_DATA_WAIT: cover property (wp && wait_q.wait_request == WRQ_DATA);
  COV_ADDR_WAIT: cover property (wp && wait_q.wait_request == WRQ_ADDR);
  COV_WRAP: cover property (rise && cnt_q == CNT_NINE && !cnt_clr);
  COV_BUSY: cover property (bus && stop_det && stat_q.bus_busy_flag);

endmodule // scb_core

// *** test/scb_bus_partner.sv ***
`timescale 1ns/100ps
// ==========================================================================
// External two-wire bus master, open-drain lines with pull-ups
module scb_bus_partner
  import scb_pkg::*;
(
  input  wire logic scl_w,
  input  wire logic sda_w,
  output logic      scl_low,
  output logic      sda_low
);
  localparam int HALF = SCK_PERIOD_NS / 2;

  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // ==========================================================================
  // Start: data released with clock low, then data falls while clock high
  task automatic start_cond();
    #(CLK_PERIOD_NS / 4);
    scl_low = 1'b1;
    #(HALF / 2);
    sda_low = 1'b0;
    #(HALF / 2);
    scl_low = 1'b0;
    #HALF;
    sda_low = 1'b1;
    #HALF;
  endtask

  // ==========================================================================
  // Stop: data rises while clock high
  task automatic stop_cond();
    #(CLK_PERIOD_NS / 4);
    scl_low = 1'b1;
    sda_low = 1'b1;
    #HALF;
    scl_low = 1'b0;
    #HALF;
    sda_low = 1'b0;
    #HALF;
  endtask

  // ==========================================================================
  // Clock pulses: new data in the low phase, waits while the line is held low
  task automatic pulse(input int n);
    #(CLK_PERIOD_NS / 4);
    for (int i = 0; i < n; i++) begin
      scl_low = 1'b1;
      #(HALF / 2);
      sda_low = 1'($urandom_range(1, 0));
      #(HALF / 2);
      scl_low = 1'b0;
      for (int k = 0; k < 400 && !scl_w; k++) #40;
      #HALF;
    end
  endtask

  // ==========================================================================
  // Ninth clock with a chosen acknowledge level
  task automatic ack_pulse(input logic low);
    #(CLK_PERIOD_NS / 4);
    scl_low = 1'b1;
    #(HALF / 2);
    sda_low = low;
    #(HALF / 2);
    scl_low = 1'b0;
    #HALF;
  endtask
endmodule // scb_bus_partner

// *** test/tb.sv ***
`timescale 1ns/100ps
module tb;
  import scb_pkg::*;

  logic       mclk;
  logic       nrst;
  logic       stop_clk;
  scb_mode_s  mode;
  logic [6:0] rf_addr;
  logic       rf_wr;
  logic [3:0] rf_wdata;
  logic [3:0] rf_rdata;
  logic       scl_out;
  logic       scl_oe;
  logic       sda_out;
  logic       sda_oe;
  logic       scl_low;
  logic       sda_low;
  logic       scl_w;
  logic       sda_w;
  logic       rd_req;
  logic       rd_seen;
  logic       shift_rise;
  logic       shift_fall;
  logic       strobe_clr;
  logic       ack_low;
  logic [3:0] nrise;
  logic [3:0] nfall;
  logic [6:0] ua;
  logic [5:0] e;
  logic [5:0] exp_q[$];
  int         miscompares;
  int         checks;

  // ==========================================================================
  // Line levels with pull-ups
  assign scl_w = !((scl_oe && !scl_out) || scl_low);
  assign sda_w = !((sda_oe && !sda_out) || sda_low);

  scb_core #(.HALF_CYC(4)) i_scb_core (
    .mclk       (mclk),
    .nrst       (nrst),
    .stop_clk   (stop_clk),
    .mode       (mode),
    .rf_addr    (rf_addr),
    .rf_wr      (rf_wr),
    .rf_wdata   (rf_wdata),
    .rf_rdata   (rf_rdata),
    .scl_in     (scl_w),
    .scl_out    (scl_out),
    .scl_oe     (scl_oe),
    .sda_in     (sda_w),
    .sda_out    (sda_out),
    .sda_oe     (sda_oe),
    .shift_rise (shift_rise),
    .shift_fall (shift_fall)
  );

  scb_bus_partner i_scb_bus_partner (
    .scl_w   (scl_w),
    .sda_w   (sda_w),
    .scl_low (scl_low),
    .sda_low (sda_low)
  );

  // ==========================================================================
  // Clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ==========================================================================
  // Tasks
  task automatic check(input logic [3:0] seen, input logic [3:0] expv);
    checks++;
    if (seen !== expv) begin
      miscompares++;
      $display("ERROR at %0t ns: seen 0x%h expected 0x%h", $time, seen, expv);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [3:0] d);
    @(posedge mclk);
    rf_addr  <= a;
    rf_wdata <= d;
    rf_wr    <= 1'b1;
    @(posedge mclk);
    rf_wr    <= 1'b0;
  endtask

  // Kind 0 a register read, 1 the pin drives, 2 and 3 the shift strobe counts
  task automatic note(input logic [1:0] k, input logic [6:0] a, input logic [3:0] ev);
    @(posedge mclk);
    rf_addr <= a;
    rd_req  <= 1'b1;
    exp_q.push_back({k, ev});
    @(posedge mclk);
    rd_req  <= 1'b0;
  endtask

  task automatic settle();
    repeat (6) @(posedge mclk);
  endtask

  task automatic finish_test();
    $display("Checks %0d, miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Monitor
  always @(posedge mclk) begin
    if (rd_seen && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e[5:4] == 2'h0) begin
        check(rf_rdata, e[3:0]);
      end else if (e[5:4] == 2'h1) begin
        check({1'b0, sda_oe, scl_out, scl_oe}, e[3:0]);
      end else if (e[5:4] == 2'h2) begin
        check(nrise, e[3:0]);
      end else begin
        check(nfall, e[3:0]);
      end
    end
    rd_seen <= rd_req;
  end

  // Shift strobe counters
  always @(posedge mclk) begin
    if (!nrst || strobe_clr) begin
      nrise <= 4'h0;
      nfall <= 4'h0;
    end else begin
      if (shift_rise) begin
        nrise <= nrise + 4'h1;
      end
      if (shift_fall) begin
        nfall <= nfall + 4'h1;
      end
    end
  end

  // ==========================================================================
  // Watchdog
  initial begin
    #400000;
    miscompares++;
    finish_test();
  end

  // ==========================================================================
  // Tests
  initial begin
    nrst        = 1'b0;
    stop_clk    = 1'b0;
    mode        = '0;
    rf_addr     = '0;
    rf_wr       = 1'b0;
    rf_wdata    = '0;
    rd_req      = 1'b0;
    strobe_clr  = 1'b0;
    ack_low     = 1'b0;
    miscompares = 0;
    checks      = 0;
    void'($urandom(65));
    ua = 7'($urandom);
    if (ua == RF_STATUS_ADDR || ua == RF_WAIT_ADDR) begin
      ua = ua ^ 7'h40;
    end
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    note(0, RF_STATUS_ADDR, STATUS_RESET);
    note(0, RF_WAIT_ADDR, WAIT_RESET);
    wr(RF_STATUS_ADDR, 4'($urandom));
    note(0, RF_STATUS_ADDR, 4'h0);
    wr(ua, 4'($urandom));
    note(0, ua, 4'h0);
    $display("Test reset and map done");

    mode <= '{1'b1, 1'b0, 1'b0};
    wr(RF_WAIT_ADDR, 4'h4);
    i_scb_bus_partner.start_cond();
    settle();
    note(0, RF_STATUS_ADDR, 4'h3);
    i_scb_bus_partner.pulse(8);
    settle();
    note(0, RF_STATUS_ADDR, 4'hb);
    i_scb_bus_partner.pulse(1);
    settle();
    note(0, RF_STATUS_ADDR, 4'hd);
    i_scb_bus_partner.pulse(1);
    settle();
    note(0, RF_STATUS_ADDR, 4'h1);
    i_scb_bus_partner.start_cond();
    settle();
    note(0, RF_STATUS_ADDR, 4'h3);
    i_scb_bus_partner.stop_cond();
    settle();
    note(0, RF_STATUS_ADDR, 4'h2);
    $display("Test bus flags done");

    wr(RF_WAIT_ADDR, 4'h5);
    i_scb_bus_partner.start_cond();
    i_scb_bus_partner.pulse(8);
    settle();
    note(0, RF_STATUS_ADDR, 4'hb);
    fork
      i_scb_bus_partner.pulse(1);
      begin
        repeat (12) @(posedge mclk);
        note(1, ua, 4'h5);
        note(0, RF_WAIT_ADDR, 4'h1);
        note(0, RF_STATUS_ADDR, 4'hb);
        wr(RF_WAIT_ADDR, 4'h5);
        repeat (3) @(posedge mclk);
        note(1, ua, 4'h4);
      end
    join
    settle();
    note(0, RF_STATUS_ADDR, 4'hd);
    mode <= '{1'b0, 1'b0, 1'b0};
    settle();
    note(0, RF_STATUS_ADDR, 4'h0);
    $display("Test bus slave wait done");

    mode <= '{1'b1, 1'b0, 1'b1};
    wr(RF_WAIT_ADDR, 4'h4);
    i_scb_bus_partner.start_cond();
    i_scb_bus_partner.pulse(8);
    ack_low = 1'($urandom);
    i_scb_bus_partner.ack_pulse(ack_low);
    settle();
    note(0, RF_STATUS_ADDR, 4'hd);
    note(0, RF_WAIT_ADDR, {~ack_low, 3'h4});
    mode <= '{1'b0, 1'b0, 1'b0};
    $display("Test bus transmit acknowledge done");

    wr(RF_WAIT_ADDR, 4'h5);
    strobe_clr <= 1'b1;
    @(posedge mclk);
    strobe_clr <= 1'b0;
    i_scb_bus_partner.pulse(8);
    settle();
    note(0, RF_STATUS_ADDR, 4'h8);
    note(2, ua, 4'h8);
    note(3, ua, 4'h8);
    i_scb_bus_partner.pulse(3);
    settle();
    note(0, RF_STATUS_ADDR, 4'h8);
    note(2, ua, 4'h8);
    note(3, ua, 4'h9);
    note(0, RF_WAIT_ADDR, 4'h1);
    wr(RF_WAIT_ADDR, 4'h5);
    settle();
    note(0, RF_STATUS_ADDR, 4'h0);
    $display("Test external clock wait done");

    mode <= '{1'b0, 1'b1, 1'b0};
    wr(RF_WAIT_ADDR, 4'h6);
    repeat (120) @(posedge mclk);
    note(0, RF_STATUS_ADDR, 4'hc);
    note(0, RF_WAIT_ADDR, 4'h2);
    note(1, ua, 4'h3);
    repeat (40) @(posedge mclk);
    note(0, RF_STATUS_ADDR, 4'hc);
    $display("Test internal clock wait done");

    mode <= '{1'b1, 1'b1, 1'b0};
    wr(RF_WAIT_ADDR, 4'h5);
    repeat (100) @(posedge mclk);
    note(0, RF_STATUS_ADDR, 4'h8);
    note(1, ua, 4'h5);
    note(0, RF_WAIT_ADDR, 4'h1);
    $display("Test bus master wait done");

    @(posedge mclk);
    stop_clk <= 1'b1;
    @(posedge mclk);
    stop_clk <= 1'b0;
    note(0, RF_WAIT_ADDR, 4'h0);
    repeat (4) @(posedge mclk);
    $display("Test clock stop done");
    finish_test();
  end
endmodule // tb
